// ==== hw/axil_port.sv ====
/*
 * AXI4-Lite slave protocol engine: takes write address and data in
 * either order, one read in flight, a second write held while a write response waits.
 * Assumes the owner decodes addresses and supplies read data and errors
 * combinationally in the strobe cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module axil_port #(
    parameter int AW = pcstk_pkg::AXI_ADDR_W,
    parameter int DW = pcstk_pkg::AXI_DATA_W
) (
    input  wire logic          clk,      // core clock
    input  wire logic          srst,     // sync reset
    input  wire logic [AW-1:0] awaddr,   // write address
    input  wire logic          awvalid,  // write address valid
    output logic               awready,  // write address ready
    input  wire logic [DW-1:0] wdata,    // write data
    input  wire logic [3:0]    wstrb,    // byte enables
    input  wire logic          wvalid,   // write data valid
    output logic               wready,   // write data ready
    output logic [1:0]         bresp,    // write response
    output logic               bvalid,   // write response valid
    input  wire logic          bready,   // write response ready
    input  wire logic [AW-1:0] araddr,   // read address
    input  wire logic          arvalid,  // read address valid
    output logic               arready,  // read address ready
    output logic [DW-1:0]      rdata,    // read data
    output logic [1:0]         rresp,    // read response
    output logic               rvalid,   // read data valid
    input  wire logic          rready,   // read data ready
    input  wire logic          wr_allow, // owner can take a write
    output logic               wr_en,    // register write strobe
    output logic [AW-1:0]      wr_addr,  // held write address
    output logic [DW-1:0]      wr_data,  // held write data
    output logic [3:0]         wr_strb,  // held byte enables
    input  wire logic          wr_err,   // unmapped write
    output logic               rd_en,    // register read strobe
    input  wire logic [DW-1:0] rd_data,  // data for araddr
    input  wire logic          rd_err    // unmapped read
);
    logic          have_aw, have_w, next_have_aw, next_have_w;
    logic          next_bvalid, next_rvalid;
    logic [1:0]    next_bresp, next_rresp;
    logic [AW-1:0] next_wr_addr;
    logic [DW-1:0] next_wr_data, next_rdata;
    logic [3:0]    next_wr_strb;

    assign wr_en = have_aw && have_w && !bvalid && wr_allow;
    assign rd_en = arvalid && arready;

    always_comb begin
        next_have_aw = have_aw;
        next_have_w  = have_w;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        if (awvalid && awready) begin
            next_have_aw = 1'b1;
            next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_have_w  = 1'b1;
            next_wr_data = wdata;
            next_wr_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_en) begin
            next_have_aw = 1'b0;
            next_have_w  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_err ? pcstk_pkg::RESP_SLV : pcstk_pkg::RESP_OKAY;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (rd_en) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_data;
            next_rresp  = rd_err ? pcstk_pkg::RESP_SLV : pcstk_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            have_aw <= 1'b0;
            have_w  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            bvalid  <= 1'b0;
            bresp   <= pcstk_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rresp   <= pcstk_pkg::RESP_OKAY;
            rdata   <= '0;
        end else begin
            have_aw <= next_have_aw;
            have_w  <= next_have_w;
            awready <= !next_have_aw;
            wready  <= !next_have_w;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= !next_rvalid;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== hw/pc_core.sv ====
/*
 * Program counter with high and upper latches and a 31-deep return
 * address stack, driven by the core's decode logic, registers on
 * AXI4-Lite.
 * Assumes decode issues one command per cycle and presents the
 * return address as the current counter before a call.
 */
`timescale 1ns/1ps
`default_nettype none
module pc_core #(
    parameter int AW = pcstk_pkg::AXI_ADDR_W,
    parameter int DW = pcstk_pkg::AXI_DATA_W
) (
    input  wire logic          CLK,         // 200 MHz core clock
    input  wire logic          SRST,        // sync reset, high
    input  wire logic [2:0]    CMD,         // decode command
    input  wire logic [20:0]   TARGET,      // jump, call or vector
    output logic      [20:0]   PC_ADDR,     // fetch address
    output logic      [4:0]    STACK_PTR,   // entries on stack
    input  wire logic [AW-1:0] AWADDR,      // write address
    input  wire logic          AWVALID,     // write address valid
    output logic               AWREADY,     // write address ready
    input  wire logic [DW-1:0] WDATA,       // write data
    input  wire logic [3:0]    WSTRB,       // byte enables
    input  wire logic          WVALID,      // write data valid
    output logic               WREADY,      // write data ready
    output logic [1:0]         BRESP,       // write response
    output logic               BVALID,      // write response valid
    input  wire logic          BREADY,      // write response ready
    input  wire logic [AW-1:0] ARADDR,      // read address
    input  wire logic          ARVALID,     // read address valid
    output logic               ARREADY,     // read address ready
    output logic [DW-1:0]      RDATA,       // read data
    output logic [1:0]         RRESP,       // read response
    output logic               RVALID,      // read data valid
    input  wire logic          RREADY       // read data ready
);
    localparam int PW = pcstk_pkg::STK_PTR_W;
    localparam int PCW = pcstk_pkg::PC_W;
    localparam int BW = pcstk_pkg::BYTE_W;
    localparam int UW = pcstk_pkg::UPPER_W;
    localparam int HL = pcstk_pkg::HI_LSB;
    localparam int UL = pcstk_pkg::UP_LSB;

    pcstk_pkg::core_op_t op;

    logic [PCW-1:0] pc, next_pc;
    logic [BW-1:0]  high_latch, next_high_latch;
    logic [UW-1:0]  upper_latch, next_upper_latch;
    logic           ovf, next_ovf;
    logic           unf, next_unf;

    logic           push, pop;
    logic [PCW-1:0] top_data;
    logic           full, empty;

    logic           wr_allow, wr_en, rd_en, wr_err, rd_err;
    logic [AW-1:0]  wr_addr;
    logic [DW-1:0]  wr_data, rd_data;
    logic [3:0]     wr_strb;

    logic           low_wr, low_rd, hi_wr, up_wr, stat_wr;

    // offsets that answer; everything else gets SLVERR
    function automatic logic is_mapped(input logic [AW-1:0] a);
        return (a == pcstk_pkg::OFS_PC_LOW)   ||
               (a == pcstk_pkg::OFS_HI_LATCH) ||
               (a == pcstk_pkg::OFS_UP_LATCH) ||
               (a == pcstk_pkg::OFS_STK_STAT);
    endfunction

    // word alignment of any loaded address
    function automatic logic [PCW-1:0] align(input logic [PCW-1:0] a);
        return {a[PCW-1:1], 1'b0};
    endfunction

    assign op = pcstk_pkg::core_op_t'(CMD);

    // bus writes wait for an idle command slot so they never race decode
    assign wr_allow = (op == pcstk_pkg::OP_NOP);
    assign wr_err   = !is_mapped(wr_addr);
    assign rd_err   = !is_mapped(ARADDR);

    assign low_wr  = wr_en && wr_strb[0] && (wr_addr == pcstk_pkg::OFS_PC_LOW);
    assign hi_wr   = wr_en && wr_strb[0] && (wr_addr == pcstk_pkg::OFS_HI_LATCH);
    assign up_wr   = wr_en && wr_strb[0] && (wr_addr == pcstk_pkg::OFS_UP_LATCH);
    assign stat_wr = wr_en && wr_strb[1] && (wr_addr == pcstk_pkg::OFS_STK_STAT);
    assign low_rd  = rd_en && (ARADDR == pcstk_pkg::OFS_PC_LOW);

    // high and upper slices reach the bus only through their latches
    always_comb begin
        rd_data = '0;
        case (ARADDR)
            pcstk_pkg::OFS_PC_LOW:   rd_data[BW-1:0] = pc[BW-1:0];
            pcstk_pkg::OFS_HI_LATCH: rd_data[BW-1:0] = high_latch;
            pcstk_pkg::OFS_UP_LATCH: rd_data[UW-1:0] = upper_latch;
            pcstk_pkg::OFS_STK_STAT: begin
                rd_data[PW-1:0]                 = STACK_PTR;
                rd_data[pcstk_pkg::STAT_OVF_BIT] = ovf;
                rd_data[pcstk_pkg::STAT_UNF_BIT] = unf;
            end
            default: rd_data = '0;
        endcase
    end

    always_comb begin
        next_pc          = pc;
        next_high_latch  = high_latch;
        next_upper_latch = upper_latch;
        next_ovf         = ovf;
        next_unf         = unf;
        push             = 1'b0;
        pop              = 1'b0;
        // write-one-to-clear first, so a same-cycle event wins below
        if (stat_wr && wr_data[pcstk_pkg::STAT_OVF_BIT]) begin
            next_ovf = 1'b0;
        end
        if (stat_wr && wr_data[pcstk_pkg::STAT_UNF_BIT]) begin
            next_unf = 1'b0;
        end
        case (op)
            pcstk_pkg::OP_STEP: begin
                next_pc = pc + PCW'(pcstk_pkg::PC_STEP);
            end
            pcstk_pkg::OP_JUMP: begin
                next_pc = align(TARGET);
            end
            pcstk_pkg::OP_CALL, pcstk_pkg::OP_INT_ACK: begin
                push    = 1'b1;
                next_pc = align(TARGET);
                if (full) begin
                    next_ovf = 1'b1;
                end
            end
            pcstk_pkg::OP_RET: begin
                pop = 1'b1;
                if (empty) begin
                    next_pc  = pcstk_pkg::PC_RST;
                    next_unf = 1'b1;
                end else begin
                    next_pc = top_data;
                end
            end
            default: begin
                // low write pulls in both latches
                if (low_wr) begin
                    next_pc = {upper_latch, high_latch, wr_data[BW-1:1], 1'b0};
                end
            end
        endcase
        if (low_rd) begin
            next_high_latch  = pc[UL-1:HL];
            next_upper_latch = pc[PCW-1:UL];
        end
        // a direct latch write in the same cycle overrides the snapshot
        if (hi_wr) begin
            next_high_latch = wr_data[BW-1:0];
        end
        if (up_wr) begin
            next_upper_latch = wr_data[UW-1:0];
        end
    end

    // clear on reset, three slices in one word
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pc          <= pcstk_pkg::PC_RST;
            high_latch  <= pcstk_pkg::LATCH_RST;
            upper_latch <= pcstk_pkg::LATCH_RST[UW-1:0];
            ovf         <= 1'b0;
            unf         <= 1'b0;
        end else begin
            pc          <= next_pc;
            high_latch  <= next_high_latch;
            upper_latch <= next_upper_latch;
            ovf         <= next_ovf;
            unf         <= next_unf;
        end
    end

    assign PC_ADDR = pc;

    // private array, no bus path into it
    ret_stack #(
        .DEPTH (pcstk_pkg::STK_DEPTH),
        .DW    (PCW),
        .PW    (PW)
    ) u_stack (
        .clk       (CLK),
        .srst      (SRST),
        .push      (push),
        .pop       (pop),
        .push_data (pc),
        .top_data  (top_data),
        .ptr       (STACK_PTR),
        .full      (full),
        .empty     (empty)
    );

    axil_port #(
        .AW (AW),
        .DW (DW)
    ) u_bus (
        .clk      (CLK),
        .srst     (SRST),
        .awaddr   (AWADDR),
        .awvalid  (AWVALID),
        .awready  (AWREADY),
        .wdata    (WDATA),
        .wstrb    (WSTRB),
        .wvalid   (WVALID),
        .wready   (WREADY),
        .bresp    (BRESP),
        .bvalid   (BVALID),
        .bready   (BREADY),
        .araddr   (ARADDR),
        .arvalid  (ARVALID),
        .arready  (ARREADY),
        .rdata    (RDATA),
        .rresp    (RRESP),
        .rvalid   (RVALID),
        .rready   (RREADY),
        .wr_allow (wr_allow),
        .wr_en    (wr_en),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .wr_strb  (wr_strb),
        .wr_err   (wr_err),
        .rd_en    (rd_en),
        .rd_data  (rd_data),
        .rd_err   (rd_err)
    );

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_call;
        op == pcstk_pkg::OP_CALL && !full;
    endsequence

    sequence s_call_ret;
        s_call ##1 op == pcstk_pkg::OP_RET;
    endsequence

    a_pc_aligned: assert property (!pc[0])
        else $error("counter bit 0 set");
    a_step_two: assert property (op == pcstk_pkg::OP_STEP |=>
        pc == $past(pc) + PCW'(pcstk_pkg::PC_STEP))
        else $error("step did not add two");
    a_jump_direct: assert property (op == pcstk_pkg::OP_JUMP |=>
        pc == {$past(TARGET[PCW-1:1]), 1'b0})
        else $error("jump target not loaded");
    a_low_wr_load: assert property (low_wr |=>
        pc[PCW-1:HL] == {$past(upper_latch), $past(high_latch)})
        else $error("low write ignored latches");
    a_low_rd_copy: assert property (low_rd && !hi_wr && !up_wr |=>
        high_latch == $past(pc[UL-1:HL]) &&
        upper_latch == $past(pc[PCW-1:UL]))
        else $error("low read did not copy");
    a_call_push: assert property (s_call |=>
        STACK_PTR == $past(STACK_PTR) + PW'(1))
        else $error("call did not push");
    a_call_return: assert property (s_call_ret |=> pc == $past(pc, 2))
        else $error("return missed pushed address");
    a_latch_keep: assert property ((op == pcstk_pkg::OP_CALL ||
        op == pcstk_pkg::OP_RET) && !hi_wr && !up_wr && !low_rd |=>
        $stable(high_latch) && $stable(upper_latch))
        else $error("call or return touched latches");
    a_reset_clear: assert property (disable iff (1'b0) SRST |=>
        pc == '0 && STACK_PTR == '0)
        else $error("reset left counter or pointer");
endmodule
`default_nettype wire

// ==== hw/ret_stack.sv ====
/*
 * Return-address storage: a dedicated array with its own pointer,
 * outside every memory address space.
 * Assumes push and pop are never asked for in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ret_stack #(
    parameter int DEPTH = pcstk_pkg::STK_DEPTH,
    parameter int DW    = pcstk_pkg::PC_W,
    parameter int PW    = pcstk_pkg::STK_PTR_W
) (
    input  wire logic          clk,       // core clock
    input  wire logic          srst,      // sync reset
    input  wire logic          push,      // store push_data
    input  wire logic          pop,       // drop top entry
    input  wire logic [DW-1:0] push_data, // value to store
    output logic      [DW-1:0] top_data,  // newest entry
    output logic      [PW-1:0] ptr,       // entries held
    output logic               full,      // no room left
    output logic               empty      // nothing held
);
    logic [DW-1:0] mem [DEPTH];
    logic [PW-1:0] next_ptr;

    assign full     = (ptr == PW'(DEPTH));
    assign empty    = (ptr == '0);
    assign top_data = empty ? '0 : mem[ptr - PW'(1)];

    // pointer up on push, down on pop
    always_comb begin
        next_ptr = ptr;
        if (push && !full) begin
            next_ptr = ptr + PW'(1);
        end else if (pop && !empty) begin
            next_ptr = ptr - PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    // no reset on the array: only entries below ptr are ever read
    always_ff @(posedge clk) begin
        if (push && !full) begin
            mem[ptr] <= push_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_ptr_bound: assert property (ptr <= PW'(DEPTH))
        else $error("stack pointer past depth");
    a_full_hold: assert property (full && push |=> ptr == $past(ptr))
        else $error("push on full stack moved pointer");
endmodule
`default_nettype wire

// ==== inc/pcstk_pkg.sv ====
/*
 * Shared constants for the program counter and return stack block:
 * widths, register offsets, field positions, reset values and the
 * core command encoding.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none
package pcstk_pkg;
    localparam int PC_W       = 21;
    localparam int BYTE_W     = 8;
    localparam int UPPER_W    = 5;
    localparam int STK_DEPTH  = 31;
    localparam int STK_PTR_W  = 5;
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int PC_STEP    = 2;
    localparam int HI_LSB     = 8;
    localparam int UP_LSB     = 16;

    // register byte offsets
    localparam logic [7:0] OFS_PC_LOW   = 8'h00;
    localparam logic [7:0] OFS_HI_LATCH = 8'h04;
    localparam logic [7:0] OFS_UP_LATCH = 8'h08;
    localparam logic [7:0] OFS_STK_STAT = 8'h0C;

    // stack status fields
    localparam int STAT_OVF_BIT = 8;
    localparam int STAT_UNF_BIT = 9;

    localparam logic [20:0] PC_RST    = 21'h000000;
    localparam logic [7:0]  LATCH_RST = 8'h00;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    typedef enum logic [2:0] {
        OP_NOP     = 3'h0,
        OP_STEP    = 3'h1,
        OP_JUMP    = 3'h2,
        OP_CALL    = 3'h3,
        OP_INT_ACK = 3'h4,
        OP_RET     = 3'h5
    } core_op_t;
endpackage
`default_nettype wire

// ==== tb/decode_model.sv ====
/* decode partner: issues one or two core commands, then returns to idle.
   assumes a free-running core clock. */
`timescale 1ns/1ps
`default_nettype none
module decode_model (
    input  wire logic   clk,    // core clock
    output logic [2:0]  cmd,    // command to core
    output logic [20:0] target  // jump, call or vector
);
    initial begin
        cmd = pcstk_pkg::OP_NOP;
        target = 21'h000000;
    end
    // idle between commands so bus writes are never blocked
    task automatic issue(input logic [2:0] op, input logic [20:0] t);
        @(posedge clk);
        cmd <= op;
        target <= t;
        @(posedge clk);
        cmd <= pcstk_pkg::OP_NOP;
        target <= ~t;
    endtask
    // two commands on consecutive edges, then idle
    task automatic issue_pair(input logic [2:0] op_a, input logic [20:0] t_a,
                              input logic [2:0] op_b, input logic [20:0] t_b);
        @(posedge clk);
        cmd <= op_a;
        target <= t_a;
        @(posedge clk);
        cmd <= op_b;
        target <= t_b;
        @(posedge clk);
        cmd <= pcstk_pkg::OP_NOP;
        target <= ~t_b;
    endtask
endmodule
`default_nettype wire

// ==== tb/program_counter_and_call_stack_tb.sv ====
/* self-checking bench for the counter and return stack.
   assumes the decode partner and an AXI4-Lite master task pair. */
`timescale 1ns/1ps
`default_nettype none
module program_counter_and_call_stack_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  cmd;
    logic [20:0] target, pc;
    logic [4:0]  sp;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic [20:0] stk [1:31];
    int          mismatches = 0, n_checks = 0, cycles = 0;

    always #2.5 clk = ~clk;

    decode_model dec_u (.clk(clk), .cmd(cmd), .target(target));
    pc_core dut_u (.CLK(clk), .SRST(srst), .CMD(cmd), .TARGET(target), .PC_ADDR(pc),
        .STACK_PTR(sp), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic run(input logic [2:0] op, input logic [20:0] t);
        dec_u.issue(op, t);
        #1;
    endtask

    task automatic t_reset;
        rdr(8'h00);
        check(rd, 32'h0);
        check({pc, sp}, 32'h0);
    endtask

    task automatic t_step;
        for (int i = 1; i <= 3; i++) begin
            run(pcstk_pkg::OP_STEP, 21'h1FFFFF);
            check(pc, 32'(2 * i));
        end
        // spare code must hold the counter still
        run(3'h7, 21'h1FFFFF);
        check(pc, 32'h6);
    endtask

    task automatic t_jump;
        run(pcstk_pkg::OP_JUMP, 21'h1ABCD);
        check(pc, 32'h1ABCC);
        rdr(8'h04);
        check(rd, 32'h0);
        rdr(8'h00);
        check(rd, 32'hCC);
        rdr(8'h04);
        check(rd, 32'hAB);
        rdr(8'h08);
        check(rd, 32'h01);
        // call and return on consecutive edges
        dec_u.issue_pair(pcstk_pkg::OP_CALL, 21'h40, pcstk_pkg::OP_RET, 21'h0);
        #1;
        check({sp, pc}, {5'h0, 21'h1ABCC});
    endtask

    task automatic t_write;
        wr(8'h04, 32'h12);
        wr(8'h08, 32'h1F);
        wr(8'h00, 32'h57);
        check(rsp, pcstk_pkg::RESP_OKAY);
        check(pc, 32'h1F1256);
        // byte 0 strobe off: latch write must be dropped
        wstrb <= 4'hE;
        wr(8'h04, 32'h99);
        wstrb <= 4'hF;
        check(rsp, pcstk_pkg::RESP_OKAY);
        wr(8'h10, 32'h1);
        check(rsp, pcstk_pkg::RESP_SLV);
        rdr(8'h10);
        check({rsp, pc}, {pcstk_pkg::RESP_SLV, 21'h1F1256});
    endtask

    task automatic t_stack;
        // mix of calls and interrupt acknowledges up to full depth
        for (int i = 1; i <= 31; i++) begin
            stk[i] = pc;
            run(i[0] ? pcstk_pkg::OP_CALL : pcstk_pkg::OP_INT_ACK, 21'(4 * i));
            check({sp, pc}, {5'(i), 21'(4 * i)});
        end
        run(pcstk_pkg::OP_CALL, 21'h100);
        check({sp, pc}, {5'h1F, 21'h100});
        rdr(8'h0C);
        check(rd, 32'h11F);
        for (int i = 31; i >= 1; i--) begin
            run(pcstk_pkg::OP_RET, 21'h0);
            check({sp, pc}, {5'(i - 1), stk[i]});
        end
        rdr(8'h04);
        check(rd, 32'h12);
        rdr(8'h08);
        check(rd, 32'h1F);
        run(pcstk_pkg::OP_RET, 21'h0);
        check(pc, 32'h0);
        rdr(8'h0C);
        check(rd, 32'h300);
        wr(8'h0C, 32'h300);
        rdr(8'h0C);
        check(rd, 32'h0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_step;
        t_jump;
        t_write;
        t_stack;
        complete_run;
    end
endmodule
`default_nettype wire
